// file: include/roller_screw_consts.vh
`ifndef ROLLER_SCREW_CONSTS_VH
`define ROLLER_SCREW_CONSTS_VH

// ----------------------------------------------------------------
// Mode state codes (one-hot)
// ----------------------------------------------------------------
`define MODE_REAL          2'b01
`define MODE_VIRT          2'b10

// ----------------------------------------------------------------
// Real-mode unit codes
// ----------------------------------------------------------------
`define UNIT_MM            2'h0
`define UNIT_INCH          2'h1
`define UNIT_DEGREE        2'h2
`define UNIT_PULSE         2'h3

// ----------------------------------------------------------------
// Ratio format: unsigned Q16.16
// ----------------------------------------------------------------
`define RATIO_FRAC_BITS    16
`define RATIO_ONE          32'h00010000

// ----------------------------------------------------------------
// Cycle speed monitor
// ----------------------------------------------------------------
`define SEC_PER_MIN        6'h3c
`define PI_Q16             18'h3243f
`define MON_SCALE_MM       10'h064
`define MON_SCALE_INCH     10'h3e8
`define DIAM_DIV_MM        17'h02710
`define DIAM_DIV_INCH      17'h186a0

// ----------------------------------------------------------------
// Droop check
// ----------------------------------------------------------------
`define DROOP_UNIT         7'h64
`define DROOP_DEFAULT      16'hffff

// ----------------------------------------------------------------
// Torque limit
// ----------------------------------------------------------------
`define TQ_DEFAULT         16'h012c
`define TQ_D_LO1           13'h0320
`define TQ_D_HI1           13'h0bfd
`define TQ_D_LO2           13'h0c08
`define TQ_D_HI2           13'h1fff
`define TQ_W_HI            13'h1fff

// ----------------------------------------------------------------
// Axis comment
// ----------------------------------------------------------------
`define COMMENT_LEN        32
`define COMMENT_IDX_W      5

`endif

// file: rtl/ratio_scale.v
`timescale 1ns/1ps
`default_nettype none
`include "roller_screw_consts.vh"

module ratio_scale (
   input  wire [31:0] value_i,
   input  wire [31:0] ratio_i,
   output wire [31:0] scaled_o
);

   // ----------------------------------------------------------------
   // Signed value times unsigned Q16.16 ratio
   // ----------------------------------------------------------------
   // Low integer word kept; overflow wraps like the pulse counters
   wire signed [64:0] prod;

   assign prod     = $signed({{33{value_i[31]}}, value_i}) * $signed({33'h0, ratio_i});
   assign scaled_o = prod[`RATIO_FRAC_BITS+31:`RATIO_FRAC_BITS];

endmodule
`default_nettype wire

// file: rtl/sticky_flag.v
`timescale 1ns/1ps
`default_nettype none

module sticky_flag (
   input  wire clk_i,
   input  wire rst_i,
   input  wire set_i,
   input  wire clr_i,
   output wire flag_o
);

   // ----------------------------------------------------------------
   // Sticky flag
   // ----------------------------------------------------------------
   reg flag_r;

   // Set wins over clear so a same-cycle event is not lost
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         flag_r <= 1'b0;
      else if (set_i)
         flag_r <= 1'b1;
      else if (clr_i)
         flag_r <= 1'b0;
   end

   assign flag_o = flag_r;

endmodule
`default_nettype wire

// file: rtl/virtual_roller_ballscrew_output.v
`timescale 1ns/1ps
`default_nettype none
`include "roller_screw_consts.vh"

module virtual_roller_ballscrew_output (
   input  wire        CLK_I,
   input  wire        RST_I,
   input  wire        CYCLE_I,
   input  wire        VIRTUAL_I,
   input  wire        IS_SCREW_I,
   input  wire        CLUTCH_USED_I,
   input  wire        CLUTCH_ON_I,
   input  wire [31:0] DRV_SPEED_I,
   input  wire [31:0] DRV_TRAVEL_I,
   input  wire [31:0] GEAR_RATIO_I,
   input  wire [31:0] CHANGE_RATIO_I,
   input  wire [31:0] REAL_SPEED_I,
   input  wire [31:0] REAL_TRAVEL_I,
   input  wire [1:0]  REAL_UNIT_I,
   input  wire        OUT_UNIT_INCH_I,
   input  wire [31:0] ROLLER_DIAM_I,
   input  wire [31:0] ROLLER_PULSES_PER_TURN_I,
   input  wire [31:0] DEVIATION_I,
   input  wire [15:0] DROOP_LIMIT_I,
   input  wire [31:0] AXIS_SPEED_CEILING_I,
   input  wire        TQ_ASSIGNED_I,
   input  wire        TQ_IS_LINK_I,
   input  wire [12:0] TQ_ADDR_I,
   input  wire [15:0] TQ_VALUE_I,
   input  wire [15:0] BACKLASH_I,
   input  wire [31:0] FIXED_TRAVEL_PER_PULSE_I,
   input  wire [31:0] SCREW_PULSES_PER_TURN_I,
   input  wire        ERR_CLR_I,
   input  wire        COMMENT_WE_I,
   input  wire [4:0]  COMMENT_WIDX_I,
   input  wire [7:0]  COMMENT_WDATA_I,
   input  wire [4:0]  COMMENT_RIDX_I,
   output wire [31:0] CMD_SPEED_O,
   output wire [31:0] CMD_TRAVEL_O,
   output wire        CMD_VALID_O,
   output wire [31:0] FEED_POS_O,
   output wire [31:0] MONITOR_O,
   output wire        AXIS_ERROR_FLAG_O,
   output wire        MODE_ERR_O,
   output wire [15:0] TQ_LIMIT_O,
   output wire        TQ_ADDR_ERR_O,
   output wire [31:0] TRAVEL_PER_PULSE_O,
   output wire [31:0] SCREW_PPT_O,
   output wire [7:0]  COMMENT_RDATA_O
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   reg  [1:0]   mode_r;
   reg  [31:0]  cmd_speed_r;
   reg  [31:0]  cmd_travel_r;
   reg          cmd_valid_r;
   reg  [31:0]  feed_pos_r;
   reg  [31:0]  ring_r;
   reg  [31:0]  cycle_speed_r;
   reg          dir_pos_r;
   reg  [15:0]  tq_limit_r;
   reg          tq_addr_err_r;
   reg  [31:0]  travel_per_pulse_r;
   reg  [31:0]  screw_ppt_r;
   reg  [7:0]   comment_rdata_r;
   reg  [7:0]   comment_mem [0:`COMMENT_LEN-1];

   wire [31:0]  spd_gear;
   wire [31:0]  spd_change;
   wire [31:0]  trv_gear;
   wire [31:0]  trv_change;
   wire         engaged;
   wire [31:0]  virt_speed;
   wire [31:0]  virt_travel;
   wire [31:0]  sel_speed;
   wire [31:0]  sel_travel;
   wire [31:0]  backlash_ext;
   wire         reverse;
   wire [31:0]  comp_travel;
   wire         in_virt;
   wire         to_virt;
   wire         to_real;
   wire         tq_addr_ok;
   wire [15:0]  tq_eff;
   wire [31:0]  dev_abs;
   wire [31:0]  spd_abs;
   wire [15:0]  droop_lim;
   wire [31:0]  droop_pulses;
   wire         droop_err;
   wire         speed_err;
   wire         unit_err;
   wire [37:0]  ppm;
   wire [103:0] cs_num;
   wire [103:0] cs_den;
   wire [103:0] cs_quot;
   wire [9:0]   mon_scale;
   wire [16:0]  diam_div;

   // ----------------------------------------------------------------
   // Command scaling
   // ----------------------------------------------------------------
   // Gear ratio first, then speed change ratio for the roller path
   ratio_scale u_spd_gear (
      .value_i  (DRV_SPEED_I),
      .ratio_i  (GEAR_RATIO_I),
      .scaled_o (spd_gear)
   );

   ratio_scale u_spd_change (
      .value_i  (spd_gear),
      .ratio_i  (CHANGE_RATIO_I),
      .scaled_o (spd_change)
   );

   ratio_scale u_trv_gear (
      .value_i  (DRV_TRAVEL_I),
      .ratio_i  (GEAR_RATIO_I),
      .scaled_o (trv_gear)
   );

   ratio_scale u_trv_change (
      .value_i  (trv_gear),
      .ratio_i  (CHANGE_RATIO_I),
      .scaled_o (trv_change)
   );

   // Screw skips the change ratio; roller takes both
   assign engaged     = ~CLUTCH_USED_I | CLUTCH_ON_I;
   assign virt_speed  = ~engaged ? 32'h0 : (IS_SCREW_I ? spd_gear : spd_change);
   assign virt_travel = ~engaged ? 32'h0 : (IS_SCREW_I ? trv_gear : trv_change);

   assign in_virt    = (mode_r == `MODE_VIRT);
   assign sel_speed  = in_virt ? virt_speed : REAL_SPEED_I;
   assign sel_travel = in_virt ? virt_travel : REAL_TRAVEL_I;

   // ----------------------------------------------------------------
   // Backlash compensation
   // ----------------------------------------------------------------
   // Direction memory is shared by both modes, so a switch never restarts it
   assign backlash_ext = {16'h0, BACKLASH_I};
   assign reverse      = (sel_travel != 32'h0) && (sel_travel[31] == dir_pos_r);
   assign comp_travel  = !reverse ? sel_travel :
                         (sel_travel[31] ? sel_travel - backlash_ext : sel_travel + backlash_ext);

   // ----------------------------------------------------------------
   // Mode switch detection
   // ----------------------------------------------------------------
   assign to_virt = VIRTUAL_I & (mode_r == `MODE_REAL);
   assign to_real = ~VIRTUAL_I & (mode_r == `MODE_VIRT);

   // Mode state
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         mode_r <= `MODE_REAL;
      end else begin
         case (mode_r)
            `MODE_REAL: if (VIRTUAL_I) mode_r <= `MODE_VIRT;
            `MODE_VIRT: if (!VIRTUAL_I) mode_r <= `MODE_REAL;
            default:    mode_r <= `MODE_REAL;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Command, feed value and roller ring position
   // ----------------------------------------------------------------
   // Mode edges take priority; a coinciding cycle updates neither command nor position
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cmd_speed_r  <= 32'h0;
         cmd_travel_r <= 32'h0;
         cmd_valid_r  <= 1'b0;
         feed_pos_r   <= 32'h0;
         ring_r       <= 32'h0;
         dir_pos_r    <= 1'b0;
      end else begin
         cmd_valid_r <= CYCLE_I;
         if (to_virt) begin
            ring_r <= feed_pos_r;
         end else if (to_real) begin
            if (!IS_SCREW_I)
               feed_pos_r <= ring_r;
         end else if (CYCLE_I) begin
            cmd_speed_r  <= sel_speed;
            cmd_travel_r <= comp_travel;
            if (sel_travel != 32'h0)
               dir_pos_r <= ~sel_travel[31];
            if (in_virt && !IS_SCREW_I)
               ring_r <= ring_r + sel_travel;
            else
               feed_pos_r <= feed_pos_r + sel_travel;
         end
      end
   end

   // ----------------------------------------------------------------
   // Roller cycle speed monitor
   // ----------------------------------------------------------------
   // Diameter in 0.1 um or 0.00001 inch; pi in Q16; huge but once per cycle
   assign spd_abs   = cmd_speed_r[31] ? (32'h0 - cmd_speed_r) : cmd_speed_r;
   assign ppm       = {6'h0, spd_abs} * {32'h0, `SEC_PER_MIN};
   assign mon_scale = OUT_UNIT_INCH_I ? `MON_SCALE_INCH : `MON_SCALE_MM;
   assign diam_div  = OUT_UNIT_INCH_I ? `DIAM_DIV_INCH : `DIAM_DIV_MM;
   assign cs_num    = {66'h0, ppm} * {72'h0, ROLLER_DIAM_I} * {86'h0, `PI_Q16} * {94'h0, mon_scale};
   assign cs_den    = {72'h0, ROLLER_PULSES_PER_TURN_I} * {87'h0, diam_div} * {87'h0, 17'h10000};
   assign cs_quot   = (ROLLER_PULSES_PER_TURN_I == 32'h0) ? 104'h0 : cs_num / cs_den;

   // Integer result stored each cycle
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I)
         cycle_speed_r <= 32'h0;
      else if (CYCLE_I)
         cycle_speed_r <= (cs_quot[103:32] != 72'h0) ? 32'hffffffff : cs_quot[31:0];
   end

   // Feed value slot shows cycle speed while roller is virtual
   assign MONITOR_O = (in_virt && !IS_SCREW_I) ? cycle_speed_r : feed_pos_r;

   // ----------------------------------------------------------------
   // Error checks
   // ----------------------------------------------------------------
   // A zero limit is outside the legal range; default used instead
   assign dev_abs      = DEVIATION_I[31] ? (32'h0 - DEVIATION_I) : DEVIATION_I;
   assign droop_lim    = (DROOP_LIMIT_I == 16'h0) ? `DROOP_DEFAULT : DROOP_LIMIT_I;
   assign droop_pulses = {16'h0, droop_lim} * {25'h0, `DROOP_UNIT};
   assign droop_err    = CYCLE_I && (dev_abs > droop_pulses);
   // Ceiling is in pulses per second; software keeps it in range
   assign speed_err    = CYCLE_I && in_virt && (spd_abs > AXIS_SPEED_CEILING_I);
   // Screw unit must match real unit; roller accepts any
   assign unit_err     = to_virt && IS_SCREW_I && (REAL_UNIT_I != {1'b0, OUT_UNIT_INCH_I});

   sticky_flag u_axis_err (
      .clk_i  (CLK_I),
      .rst_i  (RST_I),
      .set_i  (droop_err | speed_err),
      .clr_i  (ERR_CLR_I),
      .flag_o (AXIS_ERROR_FLAG_O)
   );

   sticky_flag u_mode_err (
      .clk_i  (CLK_I),
      .rst_i  (RST_I),
      .set_i  (unit_err),
      .clr_i  (ERR_CLR_I),
      .flag_o (MODE_ERR_O)
   );

   // ----------------------------------------------------------------
   // Torque limit
   // ----------------------------------------------------------------
   // Gap between the two data ranges is rejected
   assign tq_addr_ok = TQ_IS_LINK_I ? (TQ_ADDR_I <= `TQ_W_HI) :
                       (((TQ_ADDR_I >= `TQ_D_LO1) && (TQ_ADDR_I <= `TQ_D_HI1)) ||
                        ((TQ_ADDR_I >= `TQ_D_LO2) && (TQ_ADDR_I <= `TQ_D_HI2)));
   // Value range is the writer's duty and is passed unchecked
   assign tq_eff     = (TQ_ASSIGNED_I && tq_addr_ok) ? TQ_VALUE_I : `TQ_DEFAULT;

   // Initial value at the switch, then refreshed every virtual cycle
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         tq_limit_r    <= `TQ_DEFAULT;
         tq_addr_err_r <= 1'b0;
      end else begin
         tq_addr_err_r <= TQ_ASSIGNED_I & ~tq_addr_ok;
         if (to_virt || (in_virt && CYCLE_I))
            tq_limit_r <= tq_eff;
      end
   end

   // ----------------------------------------------------------------
   // Fixed-parameter pass-through and comment store
   // ----------------------------------------------------------------
   // Screw travel per pulse only ever from the fixed parameters
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         travel_per_pulse_r <= 32'h0;
         screw_ppt_r        <= 32'h0;
         comment_rdata_r    <= 8'h0;
      end else begin
         travel_per_pulse_r <= FIXED_TRAVEL_PER_PULSE_I;
         screw_ppt_r        <= SCREW_PULSES_PER_TURN_I;
         comment_rdata_r    <= comment_mem[COMMENT_RIDX_I];
      end
   end

   // Comment bytes; no reset, read before write returns unknown
   always @(posedge CLK_I) begin
      if (COMMENT_WE_I)
         comment_mem[COMMENT_WIDX_I] <= COMMENT_WDATA_I;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign CMD_SPEED_O        = cmd_speed_r;
   assign CMD_TRAVEL_O       = cmd_travel_r;
   assign CMD_VALID_O        = cmd_valid_r;
   assign FEED_POS_O         = feed_pos_r;
   assign TQ_LIMIT_O         = tq_limit_r;
   assign TQ_ADDR_ERR_O      = tq_addr_err_r;
   assign TRAVEL_PER_PULSE_O = travel_per_pulse_r;
   assign SCREW_PPT_O        = screw_ppt_r;
   assign COMMENT_RDATA_O    = comment_rdata_r;

endmodule
`default_nettype wire

// file: tb/rs_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "roller_screw_consts.vh"
module rs_checker (
   input wire logic        CLK_I,
   input wire logic        RST_I,
   input wire logic        CYCLE_I,
   input wire logic        VIRTUAL_I,
   input wire logic        IS_SCREW_I,
   input wire logic        CLUTCH_USED_I,
   input wire logic        CLUTCH_ON_I,
   input wire logic [31:0] DEVIATION_I,
   input wire logic [15:0] DROOP_LIMIT_I,
   input wire logic        TQ_ASSIGNED_I,
   input wire logic        TQ_IS_LINK_I,
   input wire logic [12:0] TQ_ADDR_I,
   input wire logic [15:0] TQ_VALUE_I,
   input wire logic [31:0] FIXED_TRAVEL_PER_PULSE_I,
   input wire logic [31:0] SCREW_PULSES_PER_TURN_I,
   input wire logic        ERR_CLR_I,
   input wire logic [31:0] CMD_SPEED_O,
   input wire logic [31:0] CMD_TRAVEL_O,
   input wire logic        CMD_VALID_O,
   input wire logic [31:0] FEED_POS_O,
   input wire logic        AXIS_ERROR_FLAG_O,
   input wire logic [15:0] TQ_LIMIT_O,
   input wire logic        TQ_ADDR_ERR_O,
   input wire logic [31:0] TRAVEL_PER_PULSE_O,
   input wire logic [31:0] SCREW_PPT_O
);
   logic [31:0] dev_abs;
   logic [22:0] droop_lim;
   logic        d_bad;

   // -----------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------
   // Limit 0 is read as the widest window, so it never trips early
   assign dev_abs   = DEVIATION_I[31] ? -DEVIATION_I : DEVIATION_I;
   assign droop_lim = ((DROOP_LIMIT_I == 16'h0) ? `DROOP_DEFAULT : DROOP_LIMIT_I) * `DROOP_UNIT;
   assign d_bad     = (TQ_ADDR_I < `TQ_D_LO1) || (TQ_ADDR_I > `TQ_D_HI1 && TQ_ADDR_I < `TQ_D_LO2);

   // -----------------------------------------------------------
   // Properties
   // -----------------------------------------------------------
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   a_valid_after_cycle: assert property (CYCLE_I |=> CMD_VALID_O)
      else $error("valid missing after cycle");
   a_valid_only_cycle: assert property (!CYCLE_I |=> !CMD_VALID_O)
      else $error("valid without cycle strobe");
   a_clutch_off_zero: assert property (CYCLE_I && VIRTUAL_I && $past(VIRTUAL_I) && CLUTCH_USED_I
      && !CLUTCH_ON_I |=> CMD_SPEED_O == 32'h0 && CMD_TRAVEL_O == 32'h0)
      else $error("motion passed with clutch released");
   a_tq_default_used: assert property (CYCLE_I && VIRTUAL_I && !TQ_ASSIGNED_I |=> TQ_LIMIT_O == `TQ_DEFAULT)
      else $error("torque limit not at default");
   a_tq_link_loaded: assert property (CYCLE_I && VIRTUAL_I && TQ_ASSIGNED_I && TQ_IS_LINK_I
      |=> TQ_LIMIT_O == $past(TQ_VALUE_I))
      else $error("link word torque not loaded");
   a_tq_addr_bad: assert property (TQ_ASSIGNED_I && !TQ_IS_LINK_I && d_bad |=> TQ_ADDR_ERR_O)
      else $error("bad torque address accepted");
   a_droop_sets_flag: assert property (CYCLE_I && dev_abs > droop_lim |=> AXIS_ERROR_FLAG_O)
      else $error("droop overrun not flagged");
   a_flag_stays_set: assert property (AXIS_ERROR_FLAG_O && !ERR_CLR_I |=> AXIS_ERROR_FLAG_O)
      else $error("error flag dropped without clear");
   a_roller_pos_frozen: assert property (VIRTUAL_I && $past(VIRTUAL_I) && !IS_SCREW_I
      |=> $stable(FEED_POS_O)) else $error("roller feed value moved in virtual mode");
   a_fixed_params_out: assert property (!$past(RST_I) |->
      TRAVEL_PER_PULSE_O == $past(FIXED_TRAVEL_PER_PULSE_I) && SCREW_PPT_O == $past(SCREW_PULSES_PER_TURN_I))
      else $error("fixed parameters not passed");

   c_virt_roller: cover property (CYCLE_I && VIRTUAL_I && !IS_SCREW_I);
   c_flag_rise: cover property ($rose(AXIS_ERROR_FLAG_O));
   c_tq_addr_err: cover property (VIRTUAL_I && TQ_ADDR_ERR_O);
endmodule

bind virtual_roller_ballscrew_output rs_checker rs_checker_i (.*);
`default_nettype wire

// file: tb/servo_amp_model.sv
`timescale 1ns/1ps
`default_nettype none
module servo_amp_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        slow_i,
   input  wire logic        valid_i,
   input  wire logic [31:0] travel_i,
   output var  logic [31:0] dev_o
);
   // Prompt follower clears its lag at once; a slow one keeps the last step as droop
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         dev_o <= 32'h0;
      else if (valid_i)
         dev_o <= slow_i ? travel_i : 32'h0;
   end
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "roller_screw_consts.vh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_errors++; \
   $display("mismatch %s exp %h got %h", nm, ex, got); end end
module tb;
   logic        CLK_I, RST_I, CYCLE_I, VIRTUAL_I, IS_SCREW_I, CLUTCH_USED_I, CLUTCH_ON_I, OUT_UNIT_INCH_I;
   logic        TQ_ASSIGNED_I, TQ_IS_LINK_I, ERR_CLR_I, COMMENT_WE_I, CMD_VALID_O, AXIS_ERROR_FLAG_O;
   logic        MODE_ERR_O, TQ_ADDR_ERR_O, slow, neg, dir_pos;
   logic [1:0]  REAL_UNIT_I;
   logic [4:0]  COMMENT_WIDX_I, COMMENT_RIDX_I;
   logic [7:0]  COMMENT_WDATA_I, COMMENT_RDATA_O;
   logic [12:0] TQ_ADDR_I;
   logic [14:0] tq_tab [9];
   logic [15:0] DROOP_LIMIT_I, TQ_VALUE_I, BACKLASH_I, TQ_LIMIT_O;
   logic [31:0] DRV_SPEED_I, DRV_TRAVEL_I, GEAR_RATIO_I, CHANGE_RATIO_I, REAL_SPEED_I, REAL_TRAVEL_I;
   logic [31:0] ROLLER_DIAM_I, ROLLER_PULSES_PER_TURN_I, DEVIATION_I, AXIS_SPEED_CEILING_I, CMD_SPEED_O;
   logic [31:0] FIXED_TRAVEL_PER_PULSE_I, SCREW_PULSES_PER_TURN_I, CMD_TRAVEL_O, FEED_POS_O, MONITOR_O;
   logic [31:0] TRAVEL_PER_PULSE_O, SCREW_PPT_O, e_feed, e_ring, e_spd, e_trv, v;
   int          n_errors, n_compared, i;

   virtual_roller_ballscrew_output virtual_roller_ballscrew_output_i (.*);
   servo_amp_model servo_amp_model_i (.clk_i(CLK_I), .rst_i(RST_I), .slow_i(slow), .valid_i(CMD_VALID_O),
      .travel_i(CMD_TRAVEL_O), .dev_o(DEVIATION_I));

   always #2 CLK_I = ~CLK_I;

   // ------------------------------------------------------------
   // Expectation helpers
   // ------------------------------------------------------------
   // Signed value times Q16.16 ratio, low fraction bits dropped
   function automatic logic [31:0] scl(input logic [31:0] x, input logic [31:0] r);
      longint p;
      p = longint'($signed(x)) * longint'({32'h0, r});
      return p[47:16];
   endfunction

   // Cycle speed as stored: magnitude only, saturating
   function automatic logic [31:0] mon(input logic [31:0] s);
      logic [31:0]  a;
      logic [127:0] n, d;
      a = s[31] ? -s : s;
      n = 128'(a) * 60 * ROLLER_DIAM_I * `PI_Q16 * (OUT_UNIT_INCH_I ? 1000 : 100);
      d = 128'(ROLLER_PULSES_PER_TURN_I) * (OUT_UNIT_INCH_I ? 100000 : 10000) * 65536;
      if (d == 0)
         return 32'h0;
      n = n / d;
      return (n > 128'hffffffff) ? 32'hffffffff : n[31:0];
   endfunction

   task automatic tick;
      CYCLE_I = 1'b0;
      @(posedge CLK_I);
      #1;
   endtask

   // One operation cycle; strobe stays up for a back-to-back run
   task automatic run(input logic [31:0] s, input logic [31:0] t);
      logic [31:0] bl;
      DRV_SPEED_I = s;
      DRV_TRAVEL_I = t;
      REAL_SPEED_I = s;
      REAL_TRAVEL_I = t;
      e_spd = s;
      e_trv = t;
      if (VIRTUAL_I) begin
         e_spd = scl(s, GEAR_RATIO_I);
         e_trv = scl(t, GEAR_RATIO_I);
         if (!IS_SCREW_I) begin
            e_spd = scl(e_spd, CHANGE_RATIO_I);
            e_trv = scl(e_trv, CHANGE_RATIO_I);
         end
         if (CLUTCH_USED_I && !CLUTCH_ON_I) begin
            e_spd = 32'h0;
            e_trv = 32'h0;
         end
      end
      // Backlash only on a reversal, kept across mode changes
      bl = 32'h0;
      if ($signed(e_trv) > 0 && !dir_pos)
         bl = BACKLASH_I;
      if ($signed(e_trv) < 0 && dir_pos)
         bl = -BACKLASH_I;
      if (e_trv != 0)
         dir_pos = !e_trv[31];
      if (!VIRTUAL_I || IS_SCREW_I)
         e_feed = e_feed + e_trv;
      else
         e_ring = e_ring + e_trv;
      CYCLE_I = 1'b1;
      @(posedge CLK_I);
      #1;
      `CHK("valid", 1'b1, CMD_VALID_O)
      `CHK("speed", e_spd, CMD_SPEED_O)
      `CHK("travel", e_trv + bl, CMD_TRAVEL_O)
      `CHK("feed", e_feed, FEED_POS_O)
   endtask

   task automatic mode(input logic m);
      VIRTUAL_I = m;
      tick;
      if (m)
         e_ring = e_feed;
      else if (!IS_SCREW_I)
         e_feed = e_ring;
      `CHK("feed_switch", e_feed, FEED_POS_O)
   endtask

   task automatic clr;
      ERR_CLR_I = 1'b1;
      tick;
      ERR_CLR_I = 1'b0;
   endtask

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      {CYCLE_I, VIRTUAL_I, IS_SCREW_I, CLUTCH_USED_I, OUT_UNIT_INCH_I, TQ_ASSIGNED_I, TQ_IS_LINK_I} = '0;
      {ERR_CLR_I, COMMENT_WE_I, slow, dir_pos, REAL_UNIT_I, COMMENT_WIDX_I, COMMENT_RIDX_I} = '0;
      {COMMENT_WDATA_I, TQ_ADDR_I, DROOP_LIMIT_I, TQ_VALUE_I, DRV_SPEED_I, DRV_TRAVEL_I} = '0;
      {REAL_SPEED_I, REAL_TRAVEL_I, e_feed, e_ring, n_errors, n_compared} = '0;
      {CLK_I, RST_I} = 2'b01;
      CLUTCH_ON_I = 1'b1;
      GEAR_RATIO_I = `RATIO_ONE;
      CHANGE_RATIO_I = 32'h00020000;
      AXIS_SPEED_CEILING_I = 32'hffffffff;
      ROLLER_DIAM_I = 32'd1000000;
      ROLLER_PULSES_PER_TURN_I = 32'd4096;
      tq_tab = '{15'h031f, 15'h4320, 15'h4bfd, 15'h0bfe, 15'h0c07, 15'h4c08, 15'h5fff, 15'h6000, 15'h7fff};
      void'($urandom(32'hb7a9e88b));
      BACKLASH_I = 16'($urandom);
      FIXED_TRAVEL_PER_PULSE_I = $urandom;
      SCREW_PULSES_PER_TURN_I = $urandom;
      repeat (4) @(posedge CLK_I);
      #1;
      RST_I = 1'b0;
      `CHK("tq_reset", `TQ_DEFAULT, TQ_LIMIT_O)
      tick;
      `CHK("travel_per_pulse", FIXED_TRAVEL_PER_PULSE_I, TRAVEL_PER_PULSE_O)
      `CHK("screw_ppt", SCREW_PULSES_PER_TURN_I, SCREW_PPT_O)
      $display("test reset done");
      // Ring wrap through virtual mode, then cycle speed monitor
      run(32'd5, 32'h7ffffff0);
      mode(1'b1);
      run(32'd7, 32'h100);
      run(32'd9000, 32'd5);
      run(32'd9000, 32'd5);
      `CHK("monitor_mm", mon(e_spd), MONITOR_O)
      OUT_UNIT_INCH_I = 1'b1;
      run(32'd9000, 32'd5);
      `CHK("monitor_inch", mon(e_spd), MONITOR_O)
      OUT_UNIT_INCH_I = 1'b0;
      mode(1'b0);
      $display("test wrap monitor done");
      for (i = 0; i < 30; i++) begin
         IS_SCREW_I = $urandom;
         REAL_UNIT_I = 2'($urandom);
         mode(1'b1);
         `CHK("mode_err", IS_SCREW_I && REAL_UNIT_I != `UNIT_MM, MODE_ERR_O)
         clr;
         repeat (5) begin
            neg = $urandom;
            // Negative motion uses whole ratios so truncation cannot differ
            GEAR_RATIO_I = {14'h0, 2'($urandom), neg ? 16'h0 : 16'($urandom)};
            CHANGE_RATIO_I = {14'h0, 2'($urandom), neg ? 16'h0 : 16'($urandom)};
            {CLUTCH_USED_I, CLUTCH_ON_I} = 2'($urandom);
            v = neg ? -32'($urandom_range(0, 99999)) : 32'($urandom_range(0, 32'h3fffffff));
            run(v, v);
            if (IS_SCREW_I)
               `CHK("monitor_feed", e_feed, MONITOR_O)
         end
         CLUTCH_USED_I = 1'b0;
         mode(1'b0);
      end
      $display("test random done");
      IS_SCREW_I = 1'b0;
      mode(1'b1);
      TQ_ASSIGNED_I = 1'b1;
      for (i = 0; i < 9; i++) begin
         {TQ_IS_LINK_I, TQ_ADDR_I} = tq_tab[i][13:0];
         TQ_VALUE_I = 16'($urandom_range(1, 1000));
         run(32'h0, 32'h0);
         `CHK("tq_limit", tq_tab[i][14] ? TQ_VALUE_I : `TQ_DEFAULT, TQ_LIMIT_O)
         `CHK("tq_addr_err", !tq_tab[i][14], TQ_ADDR_ERR_O)
      end
      TQ_ASSIGNED_I = 1'b0;
      run(32'h0, 32'h0);
      `CHK("tq_none", `TQ_DEFAULT, TQ_LIMIT_O)
      mode(1'b0);
      {TQ_ASSIGNED_I, TQ_IS_LINK_I, TQ_ADDR_I, TQ_VALUE_I} = {2'b11, 13'h0, 16'd77};
      run(32'h0, 32'h0);
      `CHK("tq_real_hold", `TQ_DEFAULT, TQ_LIMIT_O)
      mode(1'b1);
      `CHK("tq_switch", 16'd77, TQ_LIMIT_O)
      $display("test torque done");
      // Speed ceiling boundary: equal passes, one above flags, never clamped
      {GEAR_RATIO_I, CHANGE_RATIO_I} = {2{`RATIO_ONE}};
      run(32'd1000, 32'h0);
      AXIS_SPEED_CEILING_I = 32'd1000;
      clr;
      run(32'd1000, 32'h0);
      tick;
      `CHK("flag_at_ceiling", 1'b0, AXIS_ERROR_FLAG_O)
      run(32'd1001, 32'h0);
      run(32'd1001, 32'h0);
      tick;
      `CHK("flag_over_ceiling", 1'b1, AXIS_ERROR_FLAG_O)
      AXIS_SPEED_CEILING_I = 32'hffffffff;
      mode(1'b0);
      $display("test overspeed done");
      // Droop boundary with a lagging amplifier
      slow = 1'b1;
      run(32'h0, 32'd500);
      run(32'h0, 32'd500);
      clr;
      DROOP_LIMIT_I = 16'd5;
      run(32'h0, 32'd500);
      tick;
      `CHK("droop_equal", 1'b0, AXIS_ERROR_FLAG_O)
      DROOP_LIMIT_I = 16'd4;
      run(32'h0, 32'd500);
      tick;
      `CHK("droop_over", 1'b1, AXIS_ERROR_FLAG_O)
      tick;
      `CHK("droop_sticky", 1'b1, AXIS_ERROR_FLAG_O)
      clr;
      `CHK("flag_cleared", 1'b0, AXIS_ERROR_FLAG_O)
      slow = 1'b0;
      $display("test droop done");
      for (i = 0; i < 32; i++) begin
         {COMMENT_WE_I, COMMENT_WIDX_I, COMMENT_WDATA_I} = {1'b1, i[4:0], 8'(8'h41 + i)};
         tick;
      end
      COMMENT_WE_I = 1'b0;
      for (i = 0; i < 32; i++) begin
         COMMENT_RIDX_I = i[4:0];
         tick;
         `CHK("comment", 8'(8'h41 + i), COMMENT_RDATA_O)
      end
      $display("test comment done");
      end_sim;
   end

   // Watchdog against a stalled run
   initial begin
      #200000;
      n_errors++;
      end_sim;
   end
endmodule
`default_nettype wire
